// ==== core/cso_regs.vh ====
// opcodes, field positions and reset values for the converter and system instruction group
`ifndef CSO_REGS_VH
`define CSO_REGS_VH

// ten-bit instruction words
`define CSO_OP_RESULT_TO_PAIR   10'h279
`define CSO_OP_LOW_RESULT       10'h249
`define CSO_OP_PAIR_TO_COMPARE  10'h239
`define CSO_OP_CONV_CTRL_TO_ACC 10'h244
`define CSO_OP_ACC_TO_CONV_CTRL 10'h204
`define CSO_OP_CONV_LAUNCH      10'h29f
`define CSO_OP_SKIP_CONV_DONE   10'h287
`define CSO_OP_NOP              10'h000
`define CSO_OP_BACKUP_ENTRY     10'h008
`define CSO_OP_BACKUP_ARM       10'h05b
`define CSO_OP_STATUS_TEST      10'h003
`define CSO_OP_WDT_STOP_ARM     10'h29c
`define CSO_OP_WDT_RESTART      10'h2a0
`define CSO_OP_CERAMIC_SEL      10'h29a
`define CSO_OP_RC_SEL           10'h29b
`define CSO_OP_CLK_CTRL_TO_ACC  10'h252
`define CSO_OP_ACC_TO_CLK_CTRL  10'h216

// field positions
`define CSO_COMPARE_MODE_BIT    3
`define CSO_DONE_ROUTE_BIT      2

// reset values
`define CSO_CONV_CTRL_RST       4'h0
`define CSO_CLK_CTRL_RST        4'h0
`define CSO_COMPARE_VALUE_RST   8'h00
`define CSO_NIBBLE_ZERO         4'h0

`endif

// ==== core/cso_exec.v ====
// execution unit for converter transfers, skips, back-up entry, watchdog stop and clock select
`include "cso_regs.vh"

module cso_exec (
	input  wire       ref_clk_in,          // 100 MHz system clock
	input  wire       reset_in,            // async reset, active high
	input  wire       instr_valid_in,      // one-cycle pulse: instr_in holds a fetched word
	input  wire [9:0] instr_in,            // instruction word
	input  wire [3:0] acc_in,              // current accumulator
	input  wire [3:0] regb_in,             // current second working register
	input  wire [9:0] adc_result_in,       // converter result register
	input  wire       adc_done_in,         // pulse: conversion or compare finished
	input  wire       done_route_in,       // interrupt control register two, bit 2
	input  wire       status_flag_in,      // status flag tested by the status test
	input  wire       wdt_overflow_in,     // pulse: watchdog overflow sets its flag
	output wire       pc_advance_out,      // pulse: PC steps by one
	output wire       acc_wr_out,          // pulse: load acc_data_out into A
	output wire [3:0] acc_data_out,        // new accumulator value
	output wire       regb_wr_out,         // pulse: load regb_data_out into B
	output wire [3:0] regb_data_out,       // new B value
	output wire [3:0] conv_ctrl_out,       // converter control register
	output wire [7:0] compare_value_out,   // comparator reference value
	output wire       conv_start_out,      // pulse: start A-D conversion
	output wire       compare_start_out,   // pulse: start comparator operation
	output wire       conv_done_flag_out,  // conversion done flag
	output wire       wdt_flag_out,        // watchdog overflow flag
	output wire       wdt_restart_out,     // pulse: restart watchdog count
	output wire       wdt_stopped_out,     // watchdog function stopped
	output wire       osc_ceramic_out,     // ceramic oscillator selected
	output wire       osc_rc_out,          // RC oscillator selected
	output wire       ring_osc_run_out,    // ring oscillator running
	output wire [3:0] clock_ctrl_out,      // clock control register
	output wire       backup_state_out,    // RAM back-up state, all functions halted
	output wire       skip_pending_out     // next instruction will be skipped
);

	// state registers
	reg       pc_advance_reg;
	reg       pc_advance_next;
	reg       acc_wr_reg;
	reg       acc_wr_next;
	reg [3:0] acc_data_reg;
	reg [3:0] acc_data_next;
	reg       regb_wr_reg;
	reg       regb_wr_next;
	reg [3:0] regb_data_reg;
	reg [3:0] regb_data_next;
	reg [3:0] conv_ctrl_reg;
	reg [3:0] conv_ctrl_next;
	reg [7:0] compare_value_reg;
	reg [7:0] compare_value_next;
	reg       conv_start_reg;
	reg       conv_start_next;
	reg       compare_start_reg;
	reg       compare_start_next;
	reg       conv_done_reg;
	reg       conv_done_next;
	reg       wdt_flag_reg;
	reg       wdt_flag_next;
	reg       wdt_restart_reg;
	reg       wdt_restart_next;
	reg       wdt_stopped_reg;
	reg       wdt_stopped_next;
	reg       wdt_arm_reg;
	reg       wdt_arm_next;
	reg       osc_ceramic_reg;
	reg       osc_ceramic_next;
	reg       osc_rc_reg;
	reg       osc_rc_next;
	reg       ring_run_reg;
	reg       ring_run_next;
	reg [3:0] clock_ctrl_reg;
	reg [3:0] clock_ctrl_next;
	reg       backup_arm_reg;
	reg       backup_arm_next;
	reg       backup_reg;
	reg       backup_next;
	reg       skip_reg;
	reg       skip_next;

	// matches the word in hand against one opcode; only executing words count
	function op_hit;
		input       run;
		input [9:0] word;
		input [9:0] code;
		begin
			op_hit = run & (word == code);
		end
	endfunction

	// a hardware set beats a clear in the same cycle, so no event is lost
	function flag_after;
		input cleared;
		input set;
		begin
			flag_after = cleared | set;
		end
	endfunction

	// an instruction is taken whenever the core is awake; it executes unless skipped
	wire taken   = instr_valid_in & ~backup_reg;
	wire execute = taken & ~skip_reg;

	wire compare_mode = conv_ctrl_reg[`CSO_COMPARE_MODE_BIT];
	wire done_routed  = done_route_in;
	// the converter and watchdog are halted in back-up, so a late event must not latch
	wire done_event   = adc_done_in & ~backup_reg;
	wire wdt_event    = wdt_overflow_in & ~backup_reg;

	// one decode per word; words outside this group still step the PC as plain no-operations
	wire op_res_pair   = op_hit(execute, instr_in, `CSO_OP_RESULT_TO_PAIR);
	wire op_low_res    = op_hit(execute, instr_in, `CSO_OP_LOW_RESULT);
	wire op_pair_cmp   = op_hit(execute, instr_in, `CSO_OP_PAIR_TO_COMPARE);
	wire op_cc_to_acc  = op_hit(execute, instr_in, `CSO_OP_CONV_CTRL_TO_ACC);
	wire op_acc_to_cc  = op_hit(execute, instr_in, `CSO_OP_ACC_TO_CONV_CTRL);
	wire op_launch     = op_hit(execute, instr_in, `CSO_OP_CONV_LAUNCH);
	wire op_skip_done  = op_hit(execute, instr_in, `CSO_OP_SKIP_CONV_DONE);
	wire op_bk_entry   = op_hit(execute, instr_in, `CSO_OP_BACKUP_ENTRY);
	wire op_bk_arm     = op_hit(execute, instr_in, `CSO_OP_BACKUP_ARM);
	wire op_status     = op_hit(execute, instr_in, `CSO_OP_STATUS_TEST);
	wire op_wdt_arm    = op_hit(execute, instr_in, `CSO_OP_WDT_STOP_ARM);
	wire op_wdt_rst    = op_hit(execute, instr_in, `CSO_OP_WDT_RESTART);
	wire op_ceramic    = op_hit(execute, instr_in, `CSO_OP_CERAMIC_SEL);
	wire op_rc         = op_hit(execute, instr_in, `CSO_OP_RC_SEL);
	wire op_clk_to_acc = op_hit(execute, instr_in, `CSO_OP_CLK_CTRL_TO_ACC);
	wire op_acc_to_clk = op_hit(execute, instr_in, `CSO_OP_ACC_TO_CLK_CTRL);

	always @* begin
		pc_advance_next    = taken;
		acc_wr_next        = 1'b0;
		acc_data_next      = acc_data_reg;
		regb_wr_next       = 1'b0;
		regb_data_next     = regb_data_reg;
		conv_ctrl_next     = conv_ctrl_reg;
		compare_value_next = compare_value_reg;
		conv_start_next    = 1'b0;
		compare_start_next = 1'b0;
		conv_done_next     = conv_done_reg;
		wdt_flag_next      = wdt_flag_reg;
		wdt_restart_next   = 1'b0;
		wdt_stopped_next   = wdt_stopped_reg;
		wdt_arm_next       = wdt_arm_reg;
		osc_ceramic_next   = osc_ceramic_reg;
		osc_rc_next        = osc_rc_reg;
		ring_run_next      = ring_run_reg;
		clock_ctrl_next    = clock_ctrl_reg;
		backup_arm_next    = backup_arm_reg;
		backup_next        = backup_reg;
		skip_next          = skip_reg;

		// a skip lasts exactly one taken instruction
		if (taken) begin
			skip_next = 1'b0;
		end
		// the arming words only count for the very next instruction, skipped or not
		if (taken) begin
			backup_arm_next = op_bk_arm;
			wdt_arm_next    = op_wdt_arm;
		end

		if (op_res_pair) begin
			regb_wr_next = 1'b1;
			acc_wr_next  = 1'b1;
			if (compare_mode) begin
				regb_data_next = adc_result_in[7:4];
				acc_data_next  = adc_result_in[3:0];
			end else begin
				regb_data_next = adc_result_in[9:6];
				acc_data_next  = adc_result_in[5:2];
			end
		end

		if (op_low_res) begin
			acc_wr_next   = 1'b1;
			acc_data_next = {adc_result_in[1:0], 2'b00};
		end

		// in conversion mode this word only advances the PC
		if (op_pair_cmp && compare_mode) begin
			compare_value_next = {regb_in, acc_in};
		end

		if (op_cc_to_acc) begin
			acc_wr_next   = 1'b1;
			acc_data_next = conv_ctrl_reg;
		end
		if (op_acc_to_cc) begin
			conv_ctrl_next = acc_in;
		end

		if (op_launch) begin
			conv_done_next     = 1'b0;
			conv_start_next    = ~compare_mode;
			compare_start_next = compare_mode;
		end

		// with the route bit set the flag belongs to the interrupt logic
		if (op_skip_done && !done_routed && conv_done_reg) begin
			skip_next      = 1'b1;
			conv_done_next = 1'b0;
		end

		// back-up is left only through reset; waking up is handled outside this unit
		if (op_bk_entry && backup_arm_reg) begin
			backup_next = 1'b1;
		end

		if (op_status && status_flag_in) begin
			skip_next = 1'b1;
		end

		// the restart pulse goes out even when a skip follows; the count restarts either way
		if (op_wdt_rst) begin
			wdt_restart_next = 1'b1;
			if (wdt_flag_reg) begin
				skip_next     = 1'b1;
				wdt_flag_next = 1'b0;
			end
			if (wdt_arm_reg) begin
				wdt_stopped_next = 1'b1;
			end
		end

		// nothing here restarts the ring oscillator once a real source is picked
		if (op_ceramic) begin
			osc_ceramic_next = 1'b1;
			osc_rc_next      = 1'b0;
			ring_run_next    = 1'b0;
		end
		if (op_rc) begin
			osc_ceramic_next = 1'b0;
			osc_rc_next      = 1'b1;
			ring_run_next    = 1'b0;
		end

		if (op_clk_to_acc) begin
			acc_wr_next   = 1'b1;
			acc_data_next = clock_ctrl_reg;
		end
		if (op_acc_to_clk) begin
			clock_ctrl_next = acc_in;
		end

		// hardware events win over an instruction clearing the same flag
		conv_done_next = flag_after(conv_done_next, done_event);
		wdt_flag_next  = flag_after(wdt_flag_next, wdt_event);
	end

	// the ring oscillator runs out of reset until software picks a real source
	always @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pc_advance_reg    <= 1'b0;
			acc_wr_reg        <= 1'b0;
			acc_data_reg      <= `CSO_NIBBLE_ZERO;
			regb_wr_reg       <= 1'b0;
			regb_data_reg     <= `CSO_NIBBLE_ZERO;
			conv_ctrl_reg     <= `CSO_CONV_CTRL_RST;
			compare_value_reg <= `CSO_COMPARE_VALUE_RST;
			conv_start_reg    <= 1'b0;
			compare_start_reg <= 1'b0;
			conv_done_reg     <= 1'b0;
			wdt_flag_reg      <= 1'b0;
			wdt_restart_reg   <= 1'b0;
			wdt_stopped_reg   <= 1'b0;
			wdt_arm_reg       <= 1'b0;
			osc_ceramic_reg   <= 1'b0;
			osc_rc_reg        <= 1'b0;
			ring_run_reg      <= 1'b1;
			clock_ctrl_reg    <= `CSO_CLK_CTRL_RST;
			backup_arm_reg    <= 1'b0;
			backup_reg        <= 1'b0;
			skip_reg          <= 1'b0;
		end else begin
			pc_advance_reg    <= pc_advance_next;
			acc_wr_reg        <= acc_wr_next;
			acc_data_reg      <= acc_data_next;
			regb_wr_reg       <= regb_wr_next;
			regb_data_reg     <= regb_data_next;
			conv_ctrl_reg     <= conv_ctrl_next;
			compare_value_reg <= compare_value_next;
			conv_start_reg    <= conv_start_next;
			compare_start_reg <= compare_start_next;
			conv_done_reg     <= conv_done_next;
			wdt_flag_reg      <= wdt_flag_next;
			wdt_restart_reg   <= wdt_restart_next;
			wdt_stopped_reg   <= wdt_stopped_next;
			wdt_arm_reg       <= wdt_arm_next;
			osc_ceramic_reg   <= osc_ceramic_next;
			osc_rc_reg        <= osc_rc_next;
			ring_run_reg      <= ring_run_next;
			clock_ctrl_reg    <= clock_ctrl_next;
			backup_arm_reg    <= backup_arm_next;
			backup_reg        <= backup_next;
			skip_reg          <= skip_next;
		end
	end

	// every output is a register, so no decode glitch reaches the core
	assign pc_advance_out    = pc_advance_reg;
	assign acc_wr_out        = acc_wr_reg;
	assign acc_data_out      = acc_data_reg;
	assign regb_wr_out       = regb_wr_reg;
	assign regb_data_out     = regb_data_reg;
	assign conv_ctrl_out     = conv_ctrl_reg;
	assign compare_value_out = compare_value_reg;
	assign conv_start_out    = conv_start_reg;
	assign compare_start_out = compare_start_reg;
	assign conv_done_flag_out = conv_done_reg;
	assign wdt_flag_out      = wdt_flag_reg;
	assign wdt_restart_out   = wdt_restart_reg;
	assign wdt_stopped_out   = wdt_stopped_reg;
	assign osc_ceramic_out   = osc_ceramic_reg;
	assign osc_rc_out        = osc_rc_reg;
	assign ring_osc_run_out  = ring_run_reg;
	assign clock_ctrl_out    = clock_ctrl_reg;
	assign backup_state_out  = backup_reg;
	assign skip_pending_out  = skip_reg;

endmodule // cso_exec

// ==== sim/cso_exec_sva.sv ====
// assertions for the converter and system instruction unit
`include "cso_regs.vh"
module cso_exec_sva (
	input logic       ref_clk_in,
	input logic       reset_in,
	input logic       instr_valid_in,
	input logic [9:0] instr_in,
	input logic [3:0] acc_in,
	input logic [3:0] regb_in,
	input logic [9:0] adc_result_in,
	input logic       adc_done_in,
	input logic       done_route_in,
	input logic       status_flag_in,
	input logic       pc_advance_out,
	input logic       acc_wr_out,
	input logic [3:0] acc_data_out,
	input logic       regb_wr_out,
	input logic [3:0] regb_data_out,
	input logic [3:0] conv_ctrl_out,
	input logic [7:0] compare_value_out,
	input logic       conv_start_out,
	input logic       compare_start_out,
	input logic       conv_done_flag_out,
	input logic       wdt_stopped_out,
	input logic       osc_ceramic_out,
	input logic       osc_rc_out,
	input logic       ring_osc_run_out,
	input logic       backup_state_out,
	input logic       skip_pending_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	wire tk = instr_valid_in && !backup_state_out;
	wire ex = tk && !skip_pending_out;
	wire cm = conv_ctrl_out[`CSO_COMPARE_MODE_BIT];
	sequence s_wdt_pair;
		ex && instr_in == `CSO_OP_WDT_STOP_ARM ##1 ex && instr_in == `CSO_OP_WDT_RESTART;
	endsequence
	sequence s_bku_pair;
		ex && instr_in == `CSO_OP_BACKUP_ARM ##1 ex && instr_in == `CSO_OP_BACKUP_ENTRY;
	endsequence
	a_pc_step: assert property (tk |=> pc_advance_out) else $error("no pc step");
	a_backup_halt: assert property (backup_state_out |=> !pc_advance_out) else $error("step in back-up");
	a_pair_conv: assert property (ex && instr_in == `CSO_OP_RESULT_TO_PAIR && !cm |=> acc_wr_out &&
		acc_data_out == $past(adc_result_in[5:2]) && regb_data_out == $past(adc_result_in[9:6]))
		else $error("pair transfer wrong in conversion mode");
	a_pair_cmp: assert property (ex && instr_in == `CSO_OP_RESULT_TO_PAIR && cm |=> regb_wr_out &&
		acc_data_out == $past(adc_result_in[3:0]) && regb_data_out == $past(adc_result_in[7:4]))
		else $error("pair transfer wrong in comparator mode");
	a_low_bits: assert property (ex && instr_in == `CSO_OP_LOW_RESULT |=> acc_wr_out &&
		acc_data_out == {$past(adc_result_in[1:0]), 2'b00}) else $error("low bits wrong");
	a_cmp_load: assert property (ex && instr_in == `CSO_OP_PAIR_TO_COMPARE && cm |=>
		compare_value_out == $past({regb_in, acc_in})) else $error("compare value wrong");
	a_cmp_idle: assert property (ex && instr_in == `CSO_OP_PAIR_TO_COMPARE && !cm |=>
		$stable(compare_value_out) && !acc_wr_out && !regb_wr_out) else $error("compare load in conversion mode");
	a_launch_mode: assert property (ex && instr_in == `CSO_OP_CONV_LAUNCH |=>
		conv_start_out == !$past(cm) && compare_start_out == $past(cm)) else $error("wrong start");
	a_skip_quiet: assert property (tk && skip_pending_out |=> !acc_wr_out && !regb_wr_out &&
		!conv_start_out && !compare_start_out && !skip_pending_out) else $error("skipped word acted");
	a_route_nop: assert property (ex && instr_in == `CSO_OP_SKIP_CONV_DONE && done_route_in &&
		!adc_done_in |=> !skip_pending_out && $stable(conv_done_flag_out)) else $error("done test not idle");
	a_status_skip: assert property (ex && instr_in == `CSO_OP_STATUS_TEST |=>
		skip_pending_out == $past(status_flag_in)) else $error("status skip wrong");
	a_osc_pick: assert property (ex && (instr_in == `CSO_OP_CERAMIC_SEL || instr_in == `CSO_OP_RC_SEL) |=>
		!ring_osc_run_out && osc_ceramic_out != osc_rc_out) else $error("oscillator select wrong");
	a_wdt_stop: assert property (s_wdt_pair |=> wdt_stopped_out) else $error("watchdog not stopped");
	a_bku_enter: assert property (s_bku_pair |=> backup_state_out) else $error("no back-up entry");
endmodule // cso_exec_sva
bind cso_exec cso_exec_sva chk_u (.*);

// ==== sim/tb.sv ====
// self-checking bench for the converter and system instruction unit
`include "cso_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 0, reset_in = 1, instr_valid_in = 0, adc_done_in = 0;
	logic done_route_in = 0, status_flag_in = 0, wdt_overflow_in = 0;
	logic [9:0] instr_in = 0, adc_result_in = 0, r;
	logic [3:0] acc_in = 0, regb_in = 0, a, b, c;
	logic pc_advance_out, acc_wr_out, regb_wr_out, conv_start_out, compare_start_out, conv_done_flag_out;
	logic wdt_flag_out, wdt_restart_out, wdt_stopped_out, osc_ceramic_out, osc_rc_out, ring_osc_run_out;
	logic backup_state_out, skip_pending_out;
	logic [3:0] acc_data_out, regb_data_out, conv_ctrl_out, clock_ctrl_out;
	logic [7:0] compare_value_out;
	int miscompares = 0, n_compared = 0;
	typedef struct {int ia; int ib; logic [15:0] e;} cso_note_t;
	cso_note_t q[$];
	cso_note_t n;
	cso_exec dut_u (.*);
	initial forever #5 ref_clk_in = ~ref_clk_in;
	function automatic logic [7:0] obs(int id);
		case (id)
			0: return {acc_wr_out, 3'h0, acc_data_out};
			1: return {regb_wr_out, 3'h0, regb_data_out};
			2: return {4'h0, conv_ctrl_out};
			3: return compare_value_out;
			4: return {conv_start_out, compare_start_out, conv_done_flag_out, wdt_flag_out,
				wdt_restart_out, wdt_stopped_out, backup_state_out, skip_pending_out};
			default: return {osc_ceramic_out, osc_rc_out, ring_osc_run_out, 1'h0, clock_ctrl_out};
		endcase
	endfunction
	task chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out;
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one note per taken word, compared when its pc step shows
	always @(posedge ref_clk_in) begin
		if (pc_advance_out === 1'b1) begin
			if (q.size() == 0)
				chk("unexpected step", 16'h1, 16'h0);
			else begin
				n = q.pop_front();
				chk("step result", {obs(n.ia), obs(n.ib)}, n.e);
			end
		end
	end
	task send(logic [9:0] op, logic [3:0] av, logic [3:0] bv, int ia, int ib, logic [15:0] e, bit p = 1);
		@(posedge ref_clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= op;
		acc_in <= av;
		regb_in <= bv;
		if (p)
			q.push_back('{ia, ib, e});
	endtask
	task s4(logic [9:0] op, logic [7:0] v, bit p = 1);
		send(op, a, b, 4, 4, {v, v}, p);
	endtask
	task ev(bit d, bit w);
		@(posedge ref_clk_in);
		instr_valid_in <= 1'b0;
		adc_done_in <= d;
		wdt_overflow_in <= w;
		@(posedge ref_clk_in);
		adc_done_in <= 1'b0;
		wdt_overflow_in <= 1'b0;
	endtask
	initial begin
		void'($urandom(32'h0cac50fa));
		r = 10'($urandom);
		{a, b, c} = 12'($urandom);
		adc_result_in <= r;
		repeat (16) @(posedge ref_clk_in);
		chk("reset", {obs(4), obs(5)}, 16'h0020);
		reset_in <= 1'b0;
		send(`CSO_OP_ACC_TO_CONV_CTRL, 4'h0, b, 2, 4, 16'h0000);
		send(`CSO_OP_RESULT_TO_PAIR, a, b, 0, 1, {4'h8, r[5:2], 4'h8, r[9:6]});
		send(`CSO_OP_LOW_RESULT, a, b, 0, 1, {4'h8, r[1:0], 2'b00, 4'h0, r[9:6]});
		send(`CSO_OP_PAIR_TO_COMPARE, a, b, 3, 1, {8'h00, 4'h0, r[9:6]});
		send(`CSO_OP_ACC_TO_CONV_CTRL, 4'h8, b, 2, 4, 16'h0800);
		send(`CSO_OP_CONV_CTRL_TO_ACC, a, b, 0, 2, 16'h8808);
		send(`CSO_OP_RESULT_TO_PAIR, a, b, 0, 1, {4'h8, r[3:0], 4'h8, r[7:4]});
		send(`CSO_OP_PAIR_TO_COMPARE, a, b, 3, 4, {b, a, 8'h00});
		ev(1, 0);
		send(`CSO_OP_CONV_LAUNCH, a, b, 4, 3, {8'h40, b, a});
		send(`CSO_OP_ACC_TO_CONV_CTRL, 4'h0, b, 2, 4, 16'h0000);
		s4(`CSO_OP_CONV_LAUNCH, 8'h80);
		ev(1, 0);
		s4(`CSO_OP_SKIP_CONV_DONE, 8'h01);
		send(`CSO_OP_ACC_TO_CLK_CTRL, c, b, 5, 4, 16'h2000);
		send(`CSO_OP_SKIP_CONV_DONE, a, b, 4, 5, 16'h0020);
		done_route_in <= 1'b1;
		ev(1, 0);
		send(`CSO_OP_SKIP_CONV_DONE, a, b, 4, 5, 16'h2020);
		status_flag_in <= 1'b1;
		send(`CSO_OP_NOP, a, b, 0, 4, {4'h0, r[3:0], 8'h20});
		s4(`CSO_OP_STATUS_TEST, 8'h21);
		s4(`CSO_OP_CONV_LAUNCH, 8'h20);
		status_flag_in <= 1'b0;
		s4(`CSO_OP_STATUS_TEST, 8'h20);
		send(`CSO_OP_ACC_TO_CLK_CTRL, c, b, 5, 4, {4'h2, c, 8'h20});
		send(`CSO_OP_CLK_CTRL_TO_ACC, a, b, 0, 5, {4'h8, c, 4'h2, c});
		send(`CSO_OP_CERAMIC_SEL, a, b, 5, 4, {4'h8, c, 8'h20});
		send(`CSO_OP_RC_SEL, a, b, 5, 4, {4'h4, c, 8'h20});
		ev(0, 1);
		s4(`CSO_OP_WDT_RESTART, 8'h29);
		s4(`CSO_OP_NOP, 8'h20);
		s4(`CSO_OP_WDT_RESTART, 8'h28);
		s4(`CSO_OP_WDT_STOP_ARM, 8'h20);
		s4(`CSO_OP_NOP, 8'h20);
		s4(`CSO_OP_WDT_RESTART, 8'h28);
		s4(`CSO_OP_WDT_STOP_ARM, 8'h20);
		s4(`CSO_OP_WDT_RESTART, 8'h2c);
		s4(`CSO_OP_BACKUP_ARM, 8'h24);
		s4(`CSO_OP_NOP, 8'h24);
		s4(`CSO_OP_BACKUP_ENTRY, 8'h24);
		s4(`CSO_OP_BACKUP_ARM, 8'h24);
		s4(`CSO_OP_BACKUP_ENTRY, 8'h26);
		s4(`CSO_OP_NOP, 8'h00, 0);
		ev(0, 0);
		reset_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		chk("reset again", {obs(4), obs(5)}, 16'h0020);
		reset_in <= 1'b0;
		s4(`CSO_OP_NOP, 8'h00);
		ev(0, 0);
		for (int i = 0; i < 20 && q.size() > 0; i++)
			@(posedge ref_clk_in);
		if (q.size() > 0)
			chk("drain", 16'h1, 16'h0);
		close_out();
	end
endmodule // tb
